// ---- verilog/evc_top.sv ----
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - counters advance on selected source edge
// - event pins counted regardless of cpu clocks; the code samples them on clk_i through two flops
// - two 8-bit counters or one 16-bit
// - count only while gate high
// - gate edges raise an interrupt flag
// - pwm gates counting in fixed cycle
// - per counter: pin or divided clock
// - both-edge counting on event pins
// - software clears and halts each counter
// - overflow raises interrupt request
// - module standby halts the block
// - period registers read/write, reset all ones
// - pwm data write-only, reset zero
// - edge select per pin
// - edge codes: fall, rise, both, none
// - pwm enable selects pwm over gate pin
// - clock select: pin, /2, /4, /8
// - overflow flag cleared by read-then-write-zero
module evc_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic event_in_high_i,
	input wire logic event_in_low_i,
	input wire logic gate_interrupt_pin_i,
	output logic overflow_irq_o,
	output logic gate_irq_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] prd_hi;
		logic [7:0] prd_lo;
		logic [7:0] dat_hi;
		logic [7:0] dat_lo;
		logic [7:0] edge_sel;
		logic [7:0] clk_ctl;
		logic mode16;
		logic run_hi;
		logic run_lo;
		logic stby;
		logic ovf_hi;
		logic ovf_lo;
		logic gflag;
		logic arm_hi;
		logic arm_lo;
		logic arm_g;
		logic [7:0] cnt_hi;
		logic [7:0] cnt_lo;
		logic [2:0] div;
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] prev;
		logic gprev;
		logic ack;
		logic [31:0] rdat;
		logic irq_ovf;
		logic irq_gate;
	} evc_state_t;

	evc_state_t q;
	evc_state_t d;

	evc_pwm_if pwm ();

	logic req;
	logic wr;
	logic rd;
	logic csr_wr;
	logic gate;
	logic src_hi;
	logic src_lo;
	logic inc_hi;
	logic inc_lo;
	logic wrap_lo;
	logic wrap_hi;
	logic gate_edge;
	logic [7:0] csr_rd;

	function automatic logic edge_hit(input logic [1:0] sel, input logic pv, input logic cur);
		case (sel)
			evc_pkg::EDGE_FALL: edge_hit = pv && !cur;
			evc_pkg::EDGE_RISE: edge_hit = !pv && cur;
			evc_pkg::EDGE_BOTH: edge_hit = pv != cur;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	function automatic logic clk_src(input logic [1:0] cks, input logic pin_hit,
			input logic [2:0] div);
		case (cks)
			evc_pkg::CKS_PIN: clk_src = pin_hit;
			evc_pkg::CKS_DIV2: clk_src = div[0];
			evc_pkg::CKS_DIV4: clk_src = &div[1:0];
			default: clk_src = &div;
		endcase
	endfunction : clk_src

	// ----------------------------------------
	// pwm gate generator
	// ----------------------------------------
	assign pwm.en = q.edge_sel[evc_pkg::PWM_EN_POS] && !q.stby;
	assign pwm.period = {q.prd_hi, q.prd_lo};
	assign pwm.duty = {q.dat_hi, q.dat_lo};
	assign pwm.clk_sel = q.clk_ctl[evc_pkg::PWCK_POS +: 3];

	evc_pwm_gen u_pwm (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pw(pwm.gen)
	);

	// ----------------------------------------
	// counting path
	// ----------------------------------------
	always_comb begin
		// pwm enable hands the gate over from the pin to the waveform
		gate = q.edge_sel[evc_pkg::PWM_EN_POS] ? pwm.out : q.sync2[2];
		src_hi = clk_src(q.clk_ctl[evc_pkg::CKS_HI_POS +: 2],
			edge_hit(q.edge_sel[evc_pkg::EDGE_HI_POS +: 2], q.prev[0], q.sync2[0]),
			q.div);
		src_lo = clk_src(q.clk_ctl[evc_pkg::CKS_LO_POS +: 2],
			edge_hit(q.edge_sel[evc_pkg::EDGE_LO_POS +: 2], q.prev[1], q.sync2[1]),
			q.div);
		inc_lo = q.run_lo && gate && !q.stby && src_lo;
		wrap_lo = inc_lo && (q.cnt_lo == 8'hff);
		if (q.mode16) begin
			inc_hi = wrap_lo;
		end else begin
			inc_hi = q.run_hi && gate && !q.stby && src_hi;
		end
		wrap_hi = inc_hi && (q.cnt_hi == 8'hff);
		gate_edge = !q.stby && edge_hit(q.edge_sel[evc_pkg::EDGE_GATE_POS +: 2], q.gprev, gate);
	end

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign req = wb_cyc_i && wb_stb_i && !q.ack;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign rd = req && !wb_we_i;
	assign csr_wr = wr && (wb_adr_i == evc_pkg::OFS_CSR);
	assign csr_rd = {q.ovf_hi, q.ovf_lo, q.mode16, q.run_hi, q.run_lo, 3'h0};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = q;
		// first stage only feeds the second
		d.sync1 = {gate_interrupt_pin_i, event_in_low_i, event_in_high_i};
		d.sync2 = q.sync1;
		d.prev = q.sync2;
		d.gprev = gate;
		d.div = q.div + 3'h1;
		d.ack = req;
		d.rdat = 32'h0000_0000;

		if (inc_lo) begin
			d.cnt_lo = q.cnt_lo + 8'h01;
		end
		if (inc_hi) begin
			d.cnt_hi = q.cnt_hi + 8'h01;
		end

		if (rd) begin
			case (wb_adr_i)
				evc_pkg::OFS_PRD_HI: d.rdat = {24'h000000, q.prd_hi};
				evc_pkg::OFS_PRD_LO: d.rdat = {24'h000000, q.prd_lo};
				evc_pkg::OFS_EDGE: d.rdat = {24'h000000, q.edge_sel};
				evc_pkg::OFS_CLK: d.rdat = {24'h000000, q.clk_ctl};
				evc_pkg::OFS_CSR: begin
					d.rdat = {24'h000000, csr_rd};
					d.arm_hi = q.ovf_hi;
					d.arm_lo = q.ovf_lo;
				end
				evc_pkg::OFS_CNT_HI: d.rdat = {24'h000000, q.cnt_hi};
				evc_pkg::OFS_CNT_LO: d.rdat = {24'h000000, q.cnt_lo};
				evc_pkg::OFS_GATE: begin
					d.rdat = {30'h0, q.stby, q.gflag};
					d.arm_g = q.gflag;
				end
				// data registers are write-only and read as zero
				default: d.rdat = 32'h0000_0000;
			endcase
		end

		if (wr) begin
			case (wb_adr_i)
				// hardware does not guard these against a running pwm
				evc_pkg::OFS_PRD_HI: d.prd_hi = wb_dat_i[7:0];
				evc_pkg::OFS_PRD_LO: d.prd_lo = wb_dat_i[7:0];
				evc_pkg::OFS_DAT_HI: d.dat_hi = wb_dat_i[7:0];
				evc_pkg::OFS_DAT_LO: d.dat_lo = wb_dat_i[7:0];
				evc_pkg::OFS_EDGE: d.edge_sel = wb_dat_i[7:0];
				evc_pkg::OFS_CLK: d.clk_ctl = wb_dat_i[7:0];
				evc_pkg::OFS_CSR: begin
					d.mode16 = wb_dat_i[evc_pkg::CSR_MODE16];
					d.run_hi = wb_dat_i[evc_pkg::CSR_RUN_HI];
					d.run_lo = wb_dat_i[evc_pkg::CSR_RUN_LO];
					if (wb_dat_i[evc_pkg::CSR_CLR_HI]) begin
						d.cnt_hi = 8'h00;
					end
					if (wb_dat_i[evc_pkg::CSR_CLR_LO]) begin
						d.cnt_lo = 8'h00;
					end
					if (!wb_dat_i[evc_pkg::CSR_OVF_HI] && q.arm_hi) begin
						d.ovf_hi = 1'b0;
					end
					if (!wb_dat_i[evc_pkg::CSR_OVF_LO] && q.arm_lo) begin
						d.ovf_lo = 1'b0;
					end
					d.arm_hi = 1'b0;
					d.arm_lo = 1'b0;
				end
				evc_pkg::OFS_GATE: begin
					if (!wb_dat_i[evc_pkg::GATE_FLAG] && q.arm_g) begin
						d.gflag = 1'b0;
					end
					d.arm_g = 1'b0;
					d.stby = wb_dat_i[evc_pkg::GATE_STBY];
				end
				default: d.rdat = 32'h0000_0000;
			endcase
		end

		// hardware sets win over a same-cycle clear
		if (wrap_hi) begin
			d.ovf_hi = 1'b1;
		end
		if (wrap_lo) begin
			d.ovf_lo = 1'b1;
		end
		if (gate_edge) begin
			d.gflag = 1'b1;
		end
		d.irq_ovf = d.ovf_hi || d.ovf_lo;
		d.irq_gate = d.gflag;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.prd_hi <= evc_pkg::RST_PRD;
			q.prd_lo <= evc_pkg::RST_PRD;
			q.dat_hi <= evc_pkg::RST_DAT;
			q.dat_lo <= evc_pkg::RST_DAT;
			q.edge_sel <= evc_pkg::RST_CTL;
			q.clk_ctl <= evc_pkg::RST_CTL;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o = q.rdat;
	assign wb_ack_o = q.ack;
	assign overflow_irq_o = q.irq_ovf;
	assign gate_irq_o = q.irq_gate;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_ack_once;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
	property p_gate_block;
		(!gate && !csr_wr) |=> $stable(q.cnt_lo);
	endproperty
	a_gate_block: assert property (p_gate_block) else $error("counted with gate low");
	property p_ovf_set;
		(inc_hi && q.cnt_hi == 8'hff) |=> q.ovf_hi && (q.cnt_hi == 8'h00 || $past(csr_wr));
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("high overflow missed");
	property p_ovf_hold;
		(q.ovf_hi && !csr_wr) |=> q.ovf_hi;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");
	property p_irq;
		(wrap_lo) |=> ##1 overflow_irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("overflow request missing");
	property p_cascade;
		(q.mode16 && wrap_lo && !csr_wr) |=> q.cnt_hi == $past(q.cnt_hi) + 8'h01;
	endproperty
	a_cascade: assert property (p_cascade) else $error("16-bit carry lost");
	property p_div8;
		(q.clk_ctl[5:4] == 2'b11 && q.run_lo && gate && !q.stby) |-> inc_lo == (q.div == 3'h7);
	endproperty
	a_div8: assert property (p_div8) else $error("divide by 8 wrong");
	property p_no_edge;
		(q.clk_ctl[5:4] == 2'b00 && q.edge_sel[5:4] == 2'b11) |-> !inc_lo;
	endproperty
	a_no_edge: assert property (p_no_edge) else $error("prohibited edge code counted");
	property p_gate_pin;
		(!q.edge_sel[evc_pkg::PWM_EN_POS] && !q.sync2[2]) |-> !inc_lo && !inc_hi;
	endproperty
	a_gate_pin: assert property (p_gate_pin) else $error("gate pin not selected");
	property p_stby;
		(q.stby && !csr_wr) |=> $stable(q.cnt_lo) && $stable(q.cnt_hi);
	endproperty
	a_stby: assert property (p_stby) else $error("counted in standby");
	// run bits and the low counter clear, checked apart from the gate
	property p_halt_lo;
		(!q.run_lo && !csr_wr) |=> $stable(q.cnt_lo);
	endproperty
	a_halt_lo: assert property (p_halt_lo) else $error("low counter ran while halted");
	property p_halt_hi;
		(!q.run_hi && !q.mode16 && !csr_wr) |=> $stable(q.cnt_hi);
	endproperty
	a_halt_hi: assert property (p_halt_hi) else $error("high counter ran while halted");
	property p_clr_lo;
		(csr_wr && wb_dat_i[evc_pkg::CSR_CLR_LO]) |=> q.cnt_lo == 8'h00;
	endproperty
	a_clr_lo: assert property (p_clr_lo) else $error("low counter not cleared");
	property p_div2;
		(q.clk_ctl[evc_pkg::CKS_LO_POS +: 2] == evc_pkg::CKS_DIV2
			&& q.run_lo && gate && !q.stby) |-> inc_lo == q.div[0];
	endproperty
	a_div2: assert property (p_div2) else $error("divide by 2 wrong");
	property p_gflag_hold;
		(q.gflag && !(wr && wb_adr_i == evc_pkg::OFS_GATE)) |=> q.gflag;
	endproperty
	a_gflag_hold: assert property (p_gflag_hold) else $error("gate flag lost");
	property p_hi_carry;
		(q.mode16 && !wrap_lo && !csr_wr) |=> $stable(q.cnt_hi);
	endproperty
	a_hi_carry: assert property (p_hi_carry) else $error("high moved without carry");
endmodule : evc_top
`default_nettype wire

// ---- verilog/evc_pkg.sv ----
`default_nettype none
package evc_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_PRD_HI = 8'h00;
	localparam logic [7:0] OFS_PRD_LO = 8'h04;
	localparam logic [7:0] OFS_DAT_HI = 8'h08;
	localparam logic [7:0] OFS_DAT_LO = 8'h0c;
	localparam logic [7:0] OFS_EDGE = 8'h10;
	localparam logic [7:0] OFS_CLK = 8'h14;
	localparam logic [7:0] OFS_CSR = 8'h18;
	localparam logic [7:0] OFS_CNT_HI = 8'h1c;
	localparam logic [7:0] OFS_CNT_LO = 8'h20;
	localparam logic [7:0] OFS_GATE = 8'h24;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_PRD = 8'hff;
	localparam logic [7:0] RST_DAT = 8'h00;
	localparam logic [7:0] RST_CTL = 8'h00;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int EDGE_HI_POS = 6;
	localparam int EDGE_LO_POS = 4;
	localparam int EDGE_GATE_POS = 2;
	localparam int PWM_EN_POS = 1;
	localparam int CKS_HI_POS = 6;
	localparam int CKS_LO_POS = 4;
	localparam int PWCK_POS = 1;
	localparam int CSR_OVF_HI = 7;
	localparam int CSR_OVF_LO = 6;
	localparam int CSR_MODE16 = 5;
	localparam int CSR_RUN_HI = 4;
	localparam int CSR_RUN_LO = 3;
	localparam int CSR_CLR_HI = 2;
	localparam int CSR_CLR_LO = 1;
	localparam int GATE_FLAG = 0;
	localparam int GATE_STBY = 1;
	// ----------------------------------------
	// encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_BOTH = 2'b10,
		EDGE_NONE = 2'b11
	} evc_edge_t;
	typedef enum logic [1:0] {
		CKS_PIN = 2'b00,
		CKS_DIV2 = 2'b01,
		CKS_DIV4 = 2'b10,
		CKS_DIV8 = 2'b11
	} evc_cks_t;
endpackage : evc_pkg
`default_nettype wire

// ---- verilog/evc_pwm_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface evc_pwm_if;
	logic en;
	logic [15:0] period;
	logic [15:0] duty;
	logic [2:0] clk_sel;
	logic out;
	modport gen (input en, input period, input duty, input clk_sel, output out);
	modport ctl (output en, output period, output duty, output clk_sel, input out);
endinterface : evc_pwm_if
`default_nettype wire

// ---- verilog/evc_pwm_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module evc_pwm_gen (
	input wire logic clk_i,
	input wire logic rst_i,
	evc_pwm_if.gen pw
);
	typedef struct packed {
		logic [5:0] pre;
		logic [15:0] pos;
		logic out;
	} evc_pwm_state_t;

	evc_pwm_state_t q;
	evc_pwm_state_t d;
	logic [5:0] pre_max;

	// ----------------------------------------
	// prescale: /2,/4,/8,/16, 1x0 /32, 1x1 /64
	// ----------------------------------------
	always_comb begin
		case (pw.clk_sel)
			3'h0: pre_max = 6'h01;
			3'h1: pre_max = 6'h03;
			3'h2: pre_max = 6'h07;
			3'h3: pre_max = 6'h0f;
			3'h4, 3'h6: pre_max = 6'h1f;
			default: pre_max = 6'h3f;
		endcase
	end

	always_comb begin
		d = q;
		if (!pw.en) begin
			// halted generator restarts from the top of a period
			d.pre = 6'h00;
			d.pos = 16'h0000;
			d.out = 1'b0;
		end else begin
			d.pre = (q.pre >= pre_max) ? 6'h00 : q.pre + 6'h01;
			if (q.pre >= pre_max) begin
				d.pos = (q.pos >= pw.period) ? 16'h0000 : q.pos + 16'h0001;
			end
			d.out = (q.pos < pw.duty);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pw.out = q.out;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_pwm_off;
		@(posedge clk_i) disable iff (rst_i) !pw.en |=> !pw.out && q.pos == 16'h0000;
	endproperty
	a_pwm_off: assert property (p_pwm_off) else $error("pwm not halted");
	property p_pwm_wrap;
		@(posedge clk_i) disable iff (rst_i)
			(pw.en && q.pos >= pw.period && q.pre >= pre_max) |=> q.pos == 16'h0000;
	endproperty
	a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm period overrun");
endmodule : evc_pwm_gen
`default_nettype wire

// ---- bench/evc_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// event pins and gate pin of the far side
// ----------------------------------------
module evc_src_model (
	input wire logic clk_i,
	output logic event_in_high_o,
	output logic event_in_low_o,
	output logic gate_pin_o
);
	initial begin
		event_in_high_o = 1'b0;
		event_in_low_o = 1'b0;
		gate_pin_o = 1'b0;
	end
	task automatic set_gate(input logic v);
		@(posedge clk_i);
		gate_pin_o <= v;
	endtask : set_gate
	// pulses on both pins together; w sets the width, slow or prompt
	task automatic pulses(input int n, input int w);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			event_in_high_o <= 1'b1;
			event_in_low_o <= 1'b1;
			repeat (w) @(posedge clk_i);
			event_in_high_o <= 1'b0;
			event_in_low_o <= 1'b0;
			repeat (w) @(posedge clk_i);
		end
		// let the pin synchronisers settle
		repeat (8) @(posedge clk_i);
	endtask : pulses
endmodule : evc_src_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
	logic clk_i;
	logic rst_i;
	logic cyc, stb, we, ack, ev_h, ev_l, gate, ovf_irq, gate_irq;
	logic [7:0] adr;
	logic [7:0] v;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	int fails, samples_checked;
	evc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .event_in_high_i(ev_h), .event_in_low_i(ev_l),
		.gate_interrupt_pin_i(gate), .overflow_irq_o(ovf_irq), .gate_irq_o(gate_irq));
	evc_src_model i_src (.clk_i(clk_i), .event_in_high_o(ev_h), .event_in_low_o(ev_l),
		.gate_pin_o(gate));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// bus cycles
	// ----------------------------------------
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		sel <= 4'h1;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) fails++;
		r = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		wb(1'b1, a, d, r);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		wb(1'b0, a, 8'h00, r);
	endtask : rd
	task automatic restart(input logic [7:0] csr);
		wr(evc_pkg::OFS_CSR, 8'h00);
		wr(evc_pkg::OFS_CSR, 8'h06);
		wr(evc_pkg::OFS_CSR, csr);
	endtask : restart
	task automatic cnt_is(input logic [7:0] e);
		rd(evc_pkg::OFS_CNT_LO, v);
		`CHK(v, e)
		rd(evc_pkg::OFS_CNT_HI, v);
		`CHK(v, e)
	endtask : cnt_is
	task automatic wrap_up;
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		rd(evc_pkg::OFS_PRD_HI, v); `CHK(v, 8'hff)
		rd(evc_pkg::OFS_PRD_LO, v); `CHK(v, 8'hff)
		wr(evc_pkg::OFS_PRD_LO, 8'h3c);
		rd(evc_pkg::OFS_PRD_LO, v); `CHK(v, 8'h3c)
		wr(evc_pkg::OFS_DAT_LO, 8'h5a);
		rd(evc_pkg::OFS_DAT_LO, v); `CHK(v, 8'h00)
		rd(8'h30, v); `CHK(v, 8'h00)
	endtask : t_regs
	task automatic t_gate_irq;
		wr(evc_pkg::OFS_EDGE, 8'h54);
		i_src.set_gate(1'b1);
		repeat (6) @(posedge clk_i);
		#1 `CHK(gate_irq, 1'b1)
		rd(evc_pkg::OFS_GATE, v); `CHK(v[0], 1'b1)
		wr(evc_pkg::OFS_GATE, 8'h00);
		repeat (3) @(posedge clk_i);
		#1 `CHK(gate_irq, 1'b0)
	endtask : t_gate_irq
	task automatic t_edges;
		for (int k = 0; k < 4; k++) begin
			wr(evc_pkg::OFS_EDGE, {k[1:0], k[1:0], 4'h4});
			restart(8'h18);
			i_src.pulses(3, 2 + k * 3);
			cnt_is((k == 2) ? 8'h06 : (k == 3) ? 8'h00 : 8'h03);
		end
		wr(evc_pkg::OFS_EDGE, 8'h54);
		i_src.set_gate(1'b0);
		restart(8'h18);
		i_src.pulses(3, 4);
		cnt_is(8'h00);
		i_src.set_gate(1'b1);
	endtask : t_edges
	task automatic t_div;
		for (int c = 1; c < 4; c++) begin
			wr(evc_pkg::OFS_CLK, {c[1:0], c[1:0], 4'h0});
			restart(8'h18);
			repeat (64) @(posedge clk_i);
			wr(evc_pkg::OFS_CSR, 8'h00);
			rd(evc_pkg::OFS_CNT_LO, v);
			`CHK(v >= (8'h40 >> c) && v <= (8'h48 >> c) + 8'h01, 1'b1)
			repeat (20) @(posedge clk_i);
			rd(evc_pkg::OFS_CNT_HI, v);
			`CHK(v >= (8'h40 >> c) && v <= (8'h48 >> c) + 8'h01, 1'b1)
		end
		wr(evc_pkg::OFS_CSR, 8'h06);
		cnt_is(8'h00);
	endtask : t_div
	task automatic t_ovf;
		wr(evc_pkg::OFS_CLK, 8'h10);
		restart(8'h38);
		repeat (600) @(posedge clk_i);
		wr(evc_pkg::OFS_CSR, 8'h20);
		rd(evc_pkg::OFS_CNT_HI, v); `CHK(v, 8'h01)
		#1 `CHK(ovf_irq, 1'b1)
		rd(evc_pkg::OFS_CSR, v); `CHK(v[7:6], 2'b01)
		wr(evc_pkg::OFS_CSR, 8'h20);
		repeat (3) @(posedge clk_i);
		#1 `CHK(ovf_irq, 1'b0)
		// 8-bit mode: both halves wrap once on the /2 clock
		wr(evc_pkg::OFS_CLK, 8'h50);
		restart(8'h18);
		repeat (600) @(posedge clk_i);
		wr(evc_pkg::OFS_CSR, 8'h00);
		rd(evc_pkg::OFS_CSR, v); `CHK(v[7:6], 2'b11)
		wr(evc_pkg::OFS_CSR, 8'h80);
		rd(evc_pkg::OFS_CSR, v); `CHK(v[7:6], 2'b10)
		wr(evc_pkg::OFS_CSR, 8'h00);
		rd(evc_pkg::OFS_CSR, v); `CHK(v[7:6], 2'b00)
		#1 `CHK(ovf_irq, 1'b0)
		wr(evc_pkg::OFS_CLK, 8'h00);
	endtask : t_ovf
	task automatic t_stby_pwm;
		wr(evc_pkg::OFS_GATE, 8'h02);
		restart(8'h18);
		i_src.pulses(3, 4);
		wr(evc_pkg::OFS_GATE, 8'h00);
		cnt_is(8'h00);
		wr(evc_pkg::OFS_PRD_HI, 8'h00);
		wr(evc_pkg::OFS_PRD_LO, 8'h04);
		wr(evc_pkg::OFS_DAT_HI, 8'h00);
		wr(evc_pkg::OFS_DAT_LO, 8'h00);
		wr(evc_pkg::OFS_EDGE, 8'h56);
		restart(8'h18);
		i_src.pulses(3, 4);
		cnt_is(8'h00);
		wr(evc_pkg::OFS_EDGE, 8'h54);
		wr(evc_pkg::OFS_DAT_LO, 8'h08);
		wr(evc_pkg::OFS_EDGE, 8'h56);
		restart(8'h18);
		i_src.pulses(3, 4);
		cnt_is(8'h03);
	endtask : t_stby_pwm
	initial begin
		fails = 0;
		samples_checked = 0;
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		wdat = 32'h00000000;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_gate_irq();
		t_edges();
		t_div();
		t_ovf();
		t_stby_pwm();
		wrap_up();
	end
	// whole run is well under 8000 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
